// >>> src/rmc_pkg.sv
package rmc_pkg;

  localparam int NUM_CH = 2;

  // rate modes, in button stepping order
  typedef enum logic [4:0]
  {
    RATE_AUTO          = 5'h01,
    RATE_BYPASS        = 5'h02,
    RATE_STANDARD_DEF  = 5'h04,
    RATE_HIGH_DEF      = 5'h08,
    RATE_TRIPLE_HIGH   = 5'h10
  } rmc_rate_type;

  typedef enum logic [1:0]
  {
    ST_ONLINE = 2'h1,
    ST_REBOOT = 2'h2
  } rmc_boot_type;

  // reclocker rate codes, also used for the detected rate input
  localparam logic [1:0] CODE_SD  = 2'h0;
  localparam logic [1:0] CODE_HD  = 2'h1;
  localparam logic [1:0] CODE_3G  = 2'h2;

  // register offsets
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_RATE       = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;

  // config field positions, per channel: loss mute at 2*ch, equalizer off at 2*ch+1
  localparam int CFG_LOSS_BIT  = 0;
  localparam int CFG_EQOFF_BIT = 1;
  localparam int CFG_CH_STRIDE = 2;
  // rate field: channel ch at bits [8*ch+4 : 8*ch]
  localparam int RATE_CH_STRIDE = 8;

  // status field positions
  localparam int ST_REMOTE_BIT  = 0;
  localparam int ST_ONLINE_BIT  = 1;
  localparam int ST_MUTE_BIT    = 2;
  localparam int ST_EQEN_BIT    = 4;
  localparam int ST_VALID_BIT   = 6;
  localparam int ST_LOCK_BIT    = 8;
  localparam int ST_DET_BIT     = 16;
  localparam int ST_EFFCFG_BIT  = 20;

  // interrupt bits
  localparam int IRQ_LOSS_BIT   = 0;
  localparam int IRQ_RATE_BIT   = 2;
  localparam int IRQ_BOOT_BIT   = 4;
  localparam int IRQ_WIDTH      = 5;

  // reset values
  localparam logic [3:0]  RST_CONFIG   = 4'h0;
  localparam logic [4:0]  RST_IRQ_MASK = 5'h00;

  // timing
  localparam int CLK_MHZ         = 125;
  localparam int DEBOUNCE_MS     = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_MHZ * 1000;

endpackage

// >>> src/rmc_reclocker_mode_control.sv
`timescale 1ns/1ps
// How it works
// - remote position: all settings writable over the register port
// - remote mode: buttons still step rate; loss and equalizer jumpers ignored
// - local mode (default): register config writes refused, jumpers used
// - status and configuration stay readable in local mode
// - loss jumper applies only in local mode
// - mute selected: mute outputs on no valid input, or on no lock outside bypass
// - no-mute (default): outputs stay active on loss
// - equalizer jumper used only in local mode and only in bypass
// - bypass: equalizer off when equalizer_off chosen, else on
// - each press steps auto, bypass, standard, high, triple, auto
// - auto: rate detection on, reclocker locks to any supported rate
// - bypass: no reclocking; hd slew unless valid sd input
// - fixed rate: reclock at chosen rate, detection off
// - channel b independent with same controls as channel a
// - after upload, reboot and stay offline to remote until done
module rmc_reclocker_mode_control
#(
  parameter int DEBOUNCE_CYCLES = rmc_pkg::DEBOUNCE_CYCLES
)
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        card_control_select_in,
  input  wire logic        loss_action_a_in,
  input  wire logic        loss_action_b_in,
  input  wire logic        eq_bypass_a_in,
  input  wire logic        eq_bypass_b_in,
  input  wire logic        rate_select_button_a_in,
  input  wire logic        rate_select_button_b_in,
  input  wire logic        input_valid_a_in,
  input  wire logic        input_valid_b_in,
  input  wire logic        reclock_locked_a_in,
  input  wire logic        reclock_locked_b_in,
  input  wire logic [1:0]  detected_rate_a_in,
  input  wire logic [1:0]  detected_rate_b_in,
  input  wire logic        upload_done_in,
  input  wire logic        reboot_done_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  output logic             mute_a_out,
  output logic             mute_b_out,
  output logic             eq_enable_a_out,
  output logic             eq_enable_b_out,
  output logic             reclock_bypass_a_out,
  output logic             reclock_bypass_b_out,
  output logic             auto_detect_a_out,
  output logic             auto_detect_b_out,
  output logic      [1:0]  reclock_rate_a_out,
  output logic      [1:0]  reclock_rate_b_out,
  output logic             slew_hd_a_out,
  output logic             slew_hd_b_out,
  output logic             remote_online_out,
  output logic             reboot_request_out
);

  localparam int NCH = rmc_pkg::NUM_CH;
  localparam int NPIN = 13;
  localparam int IRQ_W = rmc_pkg::IRQ_WIDTH;

  function automatic rmc_pkg::rmc_rate_type step_rate(input rmc_pkg::rmc_rate_type cur);
    case (cur)
      rmc_pkg::RATE_AUTO:         step_rate = rmc_pkg::RATE_BYPASS;
      rmc_pkg::RATE_BYPASS:       step_rate = rmc_pkg::RATE_STANDARD_DEF;
      rmc_pkg::RATE_STANDARD_DEF: step_rate = rmc_pkg::RATE_HIGH_DEF;
      rmc_pkg::RATE_HIGH_DEF:     step_rate = rmc_pkg::RATE_TRIPLE_HIGH;
      default:                    step_rate = rmc_pkg::RATE_AUTO;
    endcase
  endfunction

  function automatic logic legal_rate(input logic [4:0] code);
    legal_rate = (code == rmc_pkg::RATE_AUTO) || (code == rmc_pkg::RATE_BYPASS) ||
                 (code == rmc_pkg::RATE_STANDARD_DEF) || (code == rmc_pkg::RATE_HIGH_DEF) ||
                 (code == rmc_pkg::RATE_TRIPLE_HIGH);
  endfunction

  function automatic int cfg_pos(input int ch, input int field);
    cfg_pos = ch * rmc_pkg::CFG_CH_STRIDE + field;
  endfunction

  // jumper, status and button pins: two flip-flops before use; upload done and the register port are used unsynchronised
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  wire  [NPIN-1:0] pin_raw = {reboot_done_in, detected_rate_b_in, detected_rate_a_in,
                              reclock_locked_b_in, reclock_locked_a_in,
                              input_valid_b_in, input_valid_a_in,
                              eq_bypass_b_in, eq_bypass_a_in,
                              loss_action_b_in, loss_action_a_in};
  logic [NCH-1:0]  btn_meta;
  logic [NCH-1:0]  btn_sync;
  logic            remote_meta;
  logic            remote_sync;

  always_ff @(posedge ref_clk_in)
  begin
    pin_meta    <= pin_raw;
    pin_sync    <= pin_meta;
    btn_meta    <= {rate_select_button_b_in, rate_select_button_a_in};
    btn_sync    <= btn_meta;
    remote_meta <= card_control_select_in;
    remote_sync <= remote_meta;
  end

  wire [NCH-1:0] jp_loss  = pin_sync[1:0];
  wire [NCH-1:0] jp_eqoff = pin_sync[3:2];
  wire [NCH-1:0] valid    = pin_sync[5:4];
  wire [NCH-1:0] locked   = pin_sync[7:6];
  wire [1:0]     det_rate [NCH];
  assign det_rate[0] = pin_sync[9:8];
  assign det_rate[1] = pin_sync[11:10];
  // third stage on reboot done: it is only read as a level, so the extra cycle is harmless
  logic          boot_done_sync;
  always_ff @(posedge ref_clk_in)
  begin
    boot_done_sync <= pin_sync[NPIN-1];
  end

  // reboot sequencing
  rmc_pkg::rmc_boot_type boot_state;
  rmc_pkg::rmc_boot_type next_boot_state;
  wire online = (boot_state == rmc_pkg::ST_ONLINE);
  wire boot_finished = (boot_state == rmc_pkg::ST_REBOOT) && boot_done_sync;

  always_comb
  begin
    case (boot_state)
      rmc_pkg::ST_ONLINE: next_boot_state = upload_done_in ? rmc_pkg::ST_REBOOT : rmc_pkg::ST_ONLINE;
      rmc_pkg::ST_REBOOT: next_boot_state = boot_done_sync ? rmc_pkg::ST_ONLINE : rmc_pkg::ST_REBOOT;
      default:            next_boot_state = rmc_pkg::ST_ONLINE;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      boot_state <= rmc_pkg::ST_ONLINE;
    else
      boot_state <= next_boot_state;
  end

  // register access, refused while offline
  // offline reads answer zero so no stale status leaks out
  wire acc_wr = reg_wr_in && online;
  wire acc_rd = reg_rd_in && online;
  wire remote = remote_sync;
  wire wr_config = acc_wr && remote && (reg_addr_in == rmc_pkg::OFS_CONFIG);
  wire wr_rate   = acc_wr && remote && (reg_addr_in == rmc_pkg::OFS_RATE);
  wire wr_irqst  = acc_wr && (reg_addr_in == rmc_pkg::OFS_IRQ_STATUS);
  wire wr_irqmk  = acc_wr && (reg_addr_in == rmc_pkg::OFS_IRQ_MASK);

  logic [3:0]           cfg;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      cfg <= rmc_pkg::RST_CONFIG;
    else if (wr_config)
      cfg <= reg_wdata_in[3:0];
  end

  // per channel logic, channel b identical to channel a
  rmc_pkg::rmc_rate_type rate [NCH];
  logic [NCH-1:0] mute;
  logic [NCH-1:0] eq_en;
  logic [NCH-1:0] bypass;
  logic [NCH-1:0] auto_det;
  logic [NCH-1:0] slew_hd;
  logic [1:0]     rate_code [NCH];
  logic [NCH-1:0] press;
  logic [NCH-1:0] loss_eff;
  logic [NCH-1:0] eqoff_eff;
  logic [NCH-1:0] loss_event;
  logic [NCH-1:0] rate_event;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      logic [31:0] db_cnt;
      logic        db_stable;
      logic        loss_seen;
      wire  [4:0]  wr_code = reg_wdata_in[ch*rmc_pkg::RATE_CH_STRIDE +: 5];
      wire         wr_ok   = wr_rate && legal_rate(wr_code);

      // a press counts once the level has held for the whole debounce time
      // limitation: a press shorter than the debounce time is dropped
      always_ff @(posedge ref_clk_in)
      begin
        if (srst_in)
        begin
          db_cnt    <= '0;
          db_stable <= 1'b0;
        end
        else if (btn_sync[ch] == db_stable)
          db_cnt <= '0;
        else if (db_cnt >= 32'(DEBOUNCE_CYCLES - 1))
        begin
          db_cnt    <= '0;
          db_stable <= btn_sync[ch];
        end
        else
          db_cnt <= db_cnt + 32'h1;
      end

      assign press[ch] = (btn_sync[ch] != db_stable) && (db_cnt >= 32'(DEBOUNCE_CYCLES - 1)) &&
                         btn_sync[ch];

      // button works in either mode; a press beats a same-cycle register write
      always_ff @(posedge ref_clk_in)
      begin
        if (srst_in)
          rate[ch] <= rmc_pkg::RATE_AUTO;
        else if (press[ch])
          rate[ch] <= step_rate(rate[ch]);
        else if (wr_ok)
          rate[ch] <= rmc_pkg::rmc_rate_type'(wr_code);
      end

      assign loss_eff[ch]  = remote ? cfg[cfg_pos(ch, rmc_pkg::CFG_LOSS_BIT)]  : jp_loss[ch];
      assign eqoff_eff[ch] = remote ? cfg[cfg_pos(ch, rmc_pkg::CFG_EQOFF_BIT)] : jp_eqoff[ch];

      assign bypass[ch]   = (rate[ch] == rmc_pkg::RATE_BYPASS);
      assign auto_det[ch] = (rate[ch] == rmc_pkg::RATE_AUTO);
      // lock has no meaning in bypass, so only loss of input mutes there
      wire lost = !valid[ch] || (!bypass[ch] && !locked[ch]);
      assign mute[ch]  = loss_eff[ch] && lost;
      assign eq_en[ch] = !(bypass[ch] && eqoff_eff[ch]);

      always_comb
      begin
        case (rate[ch])
          rmc_pkg::RATE_STANDARD_DEF: rate_code[ch] = rmc_pkg::CODE_SD;
          rmc_pkg::RATE_HIGH_DEF:     rate_code[ch] = rmc_pkg::CODE_HD;
          rmc_pkg::RATE_TRIPLE_HIGH:  rate_code[ch] = rmc_pkg::CODE_3G;
          default:                    rate_code[ch] = det_rate[ch];
        endcase
      end

      wire sd_now = bypass[ch] ? (valid[ch] && det_rate[ch] == rmc_pkg::CODE_SD)
                               : (rate_code[ch] == rmc_pkg::CODE_SD);
      assign slew_hd[ch] = !sd_now;

      always_ff @(posedge ref_clk_in)
      begin
        if (srst_in)
          loss_seen <= 1'b0;
        else
          loss_seen <= lost;
      end
      assign loss_event[ch] = lost && !loss_seen;
      assign rate_event[ch] = press[ch] || wr_ok;
    end
  endgenerate

  // output flops
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      mute_a_out           <= 1'b0;
      mute_b_out           <= 1'b0;
      eq_enable_a_out      <= 1'b1;
      eq_enable_b_out      <= 1'b1;
      reclock_bypass_a_out <= 1'b0;
      reclock_bypass_b_out <= 1'b0;
      auto_detect_a_out    <= 1'b1;
      auto_detect_b_out    <= 1'b1;
      reclock_rate_a_out   <= rmc_pkg::CODE_SD;
      reclock_rate_b_out   <= rmc_pkg::CODE_SD;
      slew_hd_a_out        <= 1'b1;
      slew_hd_b_out        <= 1'b1;
    end
    else
    begin
      mute_a_out           <= mute[0];
      mute_b_out           <= mute[1];
      eq_enable_a_out      <= eq_en[0];
      eq_enable_b_out      <= eq_en[1];
      reclock_bypass_a_out <= bypass[0];
      reclock_bypass_b_out <= bypass[1];
      auto_detect_a_out    <= auto_det[0];
      auto_detect_b_out    <= auto_det[1];
      reclock_rate_a_out   <= rate_code[0];
      reclock_rate_b_out   <= rate_code[1];
      slew_hd_a_out        <= slew_hd[0];
      slew_hd_b_out        <= slew_hd[1];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      remote_online_out  <= 1'b1;
      reboot_request_out <= 1'b0;
    end
    else
    begin
      remote_online_out  <= (next_boot_state == rmc_pkg::ST_ONLINE);
      reboot_request_out <= (next_boot_state == rmc_pkg::ST_REBOOT);
    end
  end

  // interrupts: set wins over a write-one clear
  wire [IRQ_W-1:0] irq_set = {boot_finished, rate_event, loss_event};
  wire [IRQ_W-1:0] irq_clr = wr_irqst ? reg_wdata_in[IRQ_W-1:0] : '0;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      irq_status <= '0;
      irq_mask   <= rmc_pkg::RST_IRQ_MASK;
      irq_out    <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_irqmk)
        irq_mask <= reg_wdata_in[IRQ_W-1:0];
      // irq uses the next status and mask, so a clear drops it without a cycle of lag
      irq_out <= |(((irq_status & ~irq_clr) | irq_set) & (wr_irqmk ? reg_wdata_in[IRQ_W-1:0] : irq_mask));
    end
  end

  // read side: status always visible while online
  logic [31:0] status_word;
  always_comb
  begin
    status_word = '0;
    status_word[rmc_pkg::ST_REMOTE_BIT] = remote;
    status_word[rmc_pkg::ST_ONLINE_BIT] = online;
    status_word[rmc_pkg::ST_MUTE_BIT +: 2]  = mute;
    status_word[rmc_pkg::ST_EQEN_BIT +: 2]  = eq_en;
    status_word[rmc_pkg::ST_VALID_BIT +: 2] = valid;
    status_word[rmc_pkg::ST_LOCK_BIT +: 2]  = locked;
    status_word[rmc_pkg::ST_DET_BIT +: 2]   = det_rate[0];
    status_word[rmc_pkg::ST_DET_BIT+2 +: 2] = det_rate[1];
    status_word[rmc_pkg::ST_EFFCFG_BIT +: 4] = {eqoff_eff[1], loss_eff[1], eqoff_eff[0], loss_eff[0]};
  end

  wire [31:0] rate_word = {19'h0, rate[1], 3'h0, rate[0]};

  logic [31:0] rd_mux;
  always_comb
  begin
    case (reg_addr_in)
      rmc_pkg::OFS_CONFIG:     rd_mux = {28'h0, cfg};
      rmc_pkg::OFS_RATE:       rd_mux = rate_word;
      rmc_pkg::OFS_STATUS:     rd_mux = status_word;
      rmc_pkg::OFS_IRQ_STATUS: rd_mux = {27'h0, irq_status};
      rmc_pkg::OFS_IRQ_MASK:   rd_mux = {27'h0, irq_mask};
      default:                 rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      reg_rdata_out <= 32'h0;
    else
      reg_rdata_out <= acc_rd ? rd_mux : 32'h0;
  end

endmodule

// >>> tb/rmc_checker.sv
`timescale 1ns/1ps
module rmc_checker
(
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        input_valid_a_in,
  input wire logic        reclock_locked_a_in,
  input wire logic [1:0]  detected_rate_a_in,
  input wire logic        upload_done_in,
  input wire logic        reboot_done_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        mute_a_out,
  input wire logic        eq_enable_a_out,
  input wire logic        reclock_bypass_a_out,
  input wire logic        auto_detect_a_out,
  input wire logic [1:0]  reclock_rate_a_out,
  input wire logic        slew_hd_a_out,
  input wire logic        remote_online_out,
  input wire logic        reboot_request_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);
  // level windows leave slack for the pin synchronisers ahead of the output flops
  property p_rdata_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  property p_offline_read;
    reg_rd_in && !remote_online_out |=> reg_rdata_out == 32'h0;
  endproperty
  a_offline_read: assert property (p_offline_read) else $error("register read answered while offline");
  property p_upload;
    upload_done_in && remote_online_out |=> reboot_request_out && !remote_online_out;
  endproperty
  a_upload: assert property (p_upload) else $error("no reboot after upload");
  property p_reboot_back;
    $rose(reboot_done_in) && !remote_online_out |-> ##[1:10] remote_online_out;
  endproperty
  a_reboot_back: assert property (p_reboot_back) else $error("not back online after reboot");
  property p_mute_ok;
    (input_valid_a_in && reclock_locked_a_in) [*6] |-> !mute_a_out;
  endproperty
  a_mute_ok: assert property (p_mute_ok) else $error("muted with good input");
  property p_eq_on;
    !reclock_bypass_a_out [*2] |-> eq_enable_a_out;
  endproperty
  a_eq_on: assert property (p_eq_on) else $error("equalizer off outside bypass");
  property p_auto_rate;
    (auto_detect_a_out && detected_rate_a_in == rmc_pkg::CODE_HD) [*6] |-> reclock_rate_a_out == rmc_pkg::CODE_HD;
  endproperty
  a_auto_rate: assert property (p_auto_rate) else $error("auto rate not following detected");
  property p_slew;
    (reclock_bypass_a_out && !input_valid_a_in) [*6] |-> slew_hd_a_out;
  endproperty
  a_slew: assert property (p_slew) else $error("sd slew in bypass without valid input");
endmodule
bind rmc_reclocker_mode_control rmc_checker chk_u (.*);

// >>> tb/rmc_button_model.sv
`timescale 1ns/1ps
// push button with contact bounce; release lasts long enough to re-arm the debouncer
module rmc_button_model
(
  input  wire logic ref_clk_in,
  input  wire logic press_in,
  output logic      button_out,
  output logic      busy_out
);
  initial
  begin
    button_out = 1'b0;
    busy_out   = 1'b0;
    forever
    begin
      @(posedge ref_clk_in);
      if (press_in)
      begin
        busy_out   <= 1'b1;
        button_out <= 1'b1;
        @(posedge ref_clk_in) button_out <= 1'b0;
        @(posedge ref_clk_in) button_out <= 1'b1;
        repeat (12) @(posedge ref_clk_in);
        button_out <= 1'b0;
        repeat (12) @(posedge ref_clk_in);
        busy_out <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/rmc_reclocker_mode_control_tb.sv
`timescale 1ns/1ps
module rmc_reclocker_mode_control_tb;
  logic        clk, srst, sel, la, lb, ea, eb, va, vb, ka, kb, upd, rbd, we, re, pa, pb, ba, bb, busy_a, busy_b;
  logic        irq, mute_a, mute_b, eqa, eqb, byp_a, byp_b, aut_a, aut_b, slw_a, slw_b, onl, rbr;
  logic [1:0]  da, db, rta, rtb;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [8:0]  stp [5];
  int          err_total, n_checks, cycles;
  rmc_button_model bm_a (.ref_clk_in(clk), .press_in(pa), .button_out(ba), .busy_out(busy_a));
  rmc_button_model bm_b (.ref_clk_in(clk), .press_in(pb), .button_out(bb), .busy_out(busy_b));
  rmc_reclocker_mode_control #(.DEBOUNCE_CYCLES(4)) dut_u
  (
    .ref_clk_in(clk), .srst_in(srst), .card_control_select_in(sel), .loss_action_a_in(la), .loss_action_b_in(lb),
    .eq_bypass_a_in(ea), .eq_bypass_b_in(eb), .rate_select_button_a_in(ba), .rate_select_button_b_in(bb),
    .input_valid_a_in(va), .input_valid_b_in(vb), .reclock_locked_a_in(ka), .reclock_locked_b_in(kb),
    .detected_rate_a_in(da), .detected_rate_b_in(db), .upload_done_in(upd), .reboot_done_in(rbd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdata),
    .irq_out(irq), .mute_a_out(mute_a), .mute_b_out(mute_b), .eq_enable_a_out(eqa), .eq_enable_b_out(eqb),
    .reclock_bypass_a_out(byp_a), .reclock_bypass_b_out(byp_b), .auto_detect_a_out(aut_a),
    .auto_detect_b_out(aut_b), .reclock_rate_a_out(rta), .reclock_rate_b_out(rtb), .slew_hd_a_out(slw_a),
    .slew_hd_b_out(slw_b), .remote_online_out(onl), .reboot_request_out(rbr)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task end_of_test;
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      end_of_test;
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %0t ns: saw %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    cyc(4);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    v = rdata;
    chk(v & m, e);
  endtask
  // waits on the model, not a fixed time, so the call ends once the model's bounce and release are done
  task press(input logic ch);
    @(posedge clk);
    pa <= !ch;
    pb <= ch;
    @(posedge clk);
    pa <= 1'b0;
    pb <= 1'b0;
    cyc(2);
    for (int i = 0; i < 60 && (busy_a || busy_b); i++) cyc(1);
    cyc(6);
  endtask
  initial
  begin
    {sel, la, lb, ea, eb, upd, rbd, we, re, pa, pb} = '0;
    {va, vb, ka, kb} = 4'hf;
    da = rmc_pkg::CODE_HD;
    db = rmc_pkg::CODE_3G;
    addr = 8'h00;
    wdata = 32'h0;
    srst = 1'b1;
    stp = '{{5'h02, 2'b10, rmc_pkg::CODE_HD}, {5'h04, 2'b00, rmc_pkg::CODE_SD}, {5'h08, 2'b00, rmc_pkg::CODE_HD},
            {5'h10, 2'b00, rmc_pkg::CODE_3G}, {5'h01, 2'b01, rmc_pkg::CODE_HD}};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    cyc(4);
    chk({mute_a, eqa, byp_a, aut_a, onl, rbr, irq}, 7'b0101100);
    rc(rmc_pkg::OFS_CONFIG, 32'h0);
    rc(rmc_pkg::OFS_RATE, 32'h0101);
    rc(rmc_pkg::OFS_IRQ_MASK, 32'h0);
    rc(8'h20, 32'h0);
    wr(rmc_pkg::OFS_CONFIG, 32'hf);
    wr(rmc_pkg::OFS_RATE, 32'h0202);
    rc(rmc_pkg::OFS_CONFIG, 32'h0);
    rc(rmc_pkg::OFS_RATE, 32'h0101);
    rc(rmc_pkg::OFS_STATUS, 32'h2, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      press(1'b0);
      rc(rmc_pkg::OFS_RATE, 32'h0100, 32'h1f00);
      chk({v[4:0], byp_a, aut_a, rta}, stp[i]);
      chk(slw_a, (i == 1) ? 1'b0 : 1'b1);
    end
    press(1'b1);
    rc(rmc_pkg::OFS_RATE, 32'h0201);
    chk({byp_b, aut_b, rtb, slw_b, mute_b, eqb}, 7'b1010101);
    db <= rmc_pkg::CODE_SD;
    cyc(6);
    chk({rtb, slw_b}, 3'b000);
    rc(rmc_pkg::OFS_IRQ_STATUS, 32'h0c);
    chk(irq, 1'b0);
    wr(rmc_pkg::OFS_IRQ_MASK, 32'h04);
    chk(irq, 1'b1);
    wr(rmc_pkg::OFS_IRQ_STATUS, 32'h0c);
    chk(irq, 1'b0);
    rc(rmc_pkg::OFS_IRQ_STATUS, 32'h0);
    press(1'b0);
    ea <= 1'b1;
    cyc(6);
    chk(eqa, 1'b0);
    ea <= 1'b0;
    la <= 1'b1;
    va <= 1'b0;
    cyc(6);
    chk({eqa, mute_a}, 2'b11);
    rc(rmc_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
    la <= 1'b0;
    cyc(6);
    chk(mute_a, 1'b0);
    sel <= 1'b1;
    la <= 1'b1;
    ea <= 1'b1;
    cyc(6);
    chk({mute_a, eqa}, 2'b01);
    wr(rmc_pkg::OFS_CONFIG, 32'h3);
    chk({mute_a, eqa}, 2'b10);
    rc(rmc_pkg::OFS_STATUS, 32'h1, 32'h1);
    wr(rmc_pkg::OFS_RATE, 32'h0410);
    wr(rmc_pkg::OFS_RATE, 32'h0003);
    rc(rmc_pkg::OFS_RATE, 32'h0410);
    chk(rta, rmc_pkg::CODE_3G);
    press(1'b0);
    rc(rmc_pkg::OFS_RATE, 32'h0401);
    va <= 1'b1;
    wr(rmc_pkg::OFS_CONFIG, 32'h0);
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    #1;
    chk({rbr, onl}, 2'b10);
    rc(rmc_pkg::OFS_STATUS, 32'h0);
    rbd <= 1'b1;
    for (int i = 0; i < 20 && !onl; i++) cyc(1);
    rbd <= 1'b0;
    chk(onl, 1'b1);
    rc(rmc_pkg::OFS_IRQ_STATUS, 32'h10, 32'h10);
    end_of_test;
  end
endmodule
